// ===== nsc_radio_model.sv
// radio stand-in answering name lookups
`timescale 1ns/10ps
`default_nettype none
module nsc_radio_model (
  // clock and bench control
  input  wire logic        i_clk,
  input  wire logic        i_answer_en,
  input  wire logic [7:0]  i_delay,
  input  wire logic [31:0] i_addr_hi,
  input  wire logic [31:0] i_addr_lo,
  // lookup handshake
  input  wire logic        i_lookup_req,
  output var  logic        o_found,
  output var  logic [31:0] o_addr_hi,
  output var  logic [31:0] o_addr_lo
);
  logic [7:0]  cnt;   // cycles left before answering
  logic        armed; // a request is pending
  initial begin
    o_found = 1'b0;
    armed = 1'b0;
  end
  // answer after a delay, else inverted address
  always @(negedge i_clk) begin
    o_found <= 1'b0;
    o_addr_hi <= ~i_addr_hi;
    o_addr_lo <= ~i_addr_lo;
    if (i_lookup_req && i_answer_en) begin
      armed <= 1'b1;
      cnt <= i_delay;
    end else if (armed && cnt == 8'h00) begin
      armed <= 1'b0;
      o_found <= 1'b1;
      o_addr_hi <= i_addr_hi;
      o_addr_lo <= i_addr_lo;
    end else if (armed) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== nsc_regs.vh
// constants for the network join and scan configuration block
`ifndef NSC_REGS_VH
`define NSC_REGS_VH

// command codes on the configuration port
`define NSC_CMD_ROLE      3'h0
`define NSC_CMD_MASK      3'h1
`define NSC_CMD_DWELL     3'h2
`define NSC_CMD_NODE_OPT  3'h3
`define NSC_CMD_HUB_OPT   3'h4
`define NSC_CMD_DEST_LO   3'h5
`define NSC_CMD_DEST_HI   3'h6

// reset values
`define NSC_ROLE_RST      1'h0
`define NSC_MASK_RST      16'h1FFE
`define NSC_DWELL_RST     4'h4
`define NSC_NODE_OPT_RST  8'h00
`define NSC_HUB_OPT_RST   8'h00

// legal ranges and variant masks
`define NSC_NODE_OPT_MAX  32'h0000000F
`define NSC_HUB_OPT_MAX   32'h00000007
`define NSC_DWELL_MAX     32'h0000000F
`define NSC_ROLE_MAX      32'h00000001
`define NSC_MASK_MAX      32'h0000FFFF
`define NSC_MASK_HP       16'h3FFE
`define NSC_CHAN_BASE     8'h0B
`define NSC_NAME_MAX      5'h14

// node join option bits
`define NSC_NODE_ANY_PAN  0
`define NSC_NODE_ANY_CH   1
`define NSC_NODE_AUTO     2
`define NSC_NODE_POLL     3
// coordinator join option bits
`define NSC_HUB_PAN_RES   0
`define NSC_HUB_FREQ_RES  1
`define NSC_HUB_ACCEPT    2

// timing
`define NSC_CLK_KHZ       20000
`define NSC_LOOKUP_MS     200
`define NSC_LOOKUP_CYC    (`NSC_LOOKUP_MS * `NSC_CLK_KHZ)
`define NSC_BASE_US       15360
`define NSC_BASE_CYC      ((`NSC_BASE_US * `NSC_CLK_KHZ) / 1000)

`endif

// ===== nsc_scan_walk.v
// channel walker: dwells on each enabled mask bit in turn
`timescale 1ns/10ps
`default_nettype none
`include "nsc_regs.vh"

module nsc_scan_walk #(
  parameter BASE_CYCLES = `NSC_BASE_CYC
) (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  // control
  input  wire        i_start,
  input  wire [15:0] i_mask,
  input  wire [3:0]  i_dwell,
  // status
  output reg         o_busy,
  output reg  [7:0]  o_chan,
  output reg         o_done
);

  // first set bit at or above a position; 16 when none
  function [4:0] next_bit;
    input [15:0] mask;
    input [4:0]  from;
    integer      k;
    begin
      next_bit = 5'h10;
      for (k = 15; k >= 0; k = k - 1) begin
        if (mask[k] && (k >= from)) begin
          next_bit = k[4:0];
        end
      end
    end
  endfunction

  reg [15:0] mask_reg;   // mask frozen for this scan
  reg [3:0]  dwell_reg;  // exponent frozen for this scan
  reg [4:0]  idx_reg;    // channel bit in use
  reg [31:0] base_reg;   // cycles left in one base period
  reg [15:0] per_reg;    // base periods left on this channel
  wire [4:0] first_idx;  // first enabled bit of the new mask
  wire [4:0] after_idx;  // next enabled bit after the current

  assign first_idx = next_bit(i_mask, 5'h00);
  assign after_idx = next_bit(mask_reg, idx_reg + 5'h01);

  // walk: each channel takes 2^dwell base periods
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mask_reg  <= 16'h0000;
      dwell_reg <= 4'h0;
      idx_reg   <= 5'h00;
      base_reg  <= 32'h00000000;
      per_reg   <= 16'h0000;
      o_busy    <= 1'b0;
      o_chan    <= 8'h00;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_start) begin
          // only enabled channels are visited
          mask_reg  <= i_mask;
          dwell_reg <= i_dwell;
          if (first_idx[4]) begin
            // empty mask: finish at once
            o_done <= 1'b1;
          end else begin
            o_busy   <= 1'b1;
            idx_reg  <= first_idx;
            o_chan   <= `NSC_CHAN_BASE + {4'h0, first_idx[3:0]};
            base_reg <= BASE_CYCLES - 1;
            per_reg  <= (16'h0001 << i_dwell) - 16'h0001;
          end
        end
      end else if (base_reg != 32'h00000000) begin
        // inside one base period
        base_reg <= base_reg - 32'h00000001;
      end else if (per_reg != 16'h0000) begin
        // next base period on the same channel
        per_reg  <= per_reg - 16'h0001;
        base_reg <= BASE_CYCLES - 1;
      end else if (after_idx[4]) begin
        // last channel done
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end else begin
        // advance to the next enabled bit
        idx_reg  <= after_idx;
        o_chan   <= `NSC_CHAN_BASE + {4'h0, after_idx[3:0]};
        base_reg <= BASE_CYCLES - 1;
        per_reg  <= (16'h0001 << dwell_reg) - 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ===== nsc_top.v
// network join and scan configuration: settings, name lookup, scans
`timescale 1ns/10ps
`default_nettype none
`include "nsc_regs.vh"

// Operation
// - successful lookup loads destination high/low words
// - then answer ok and leave command mode
// - timeout or blank name gives error answer
// - mask restricts every active and energy scan
// - mask resets 0x1FFE; high power forbids 0,14,15
// - scan time channels times 2^dwell times base
// - dwell exponent 0 to 15, resets to 4
// - dwell sets join and reselection scan lengths
// - node bit0 allows joining any network number
// - node bit1 allows joining on any channel
// - node bit2 retries joining; beacon always joins
// - node bit3 polls coordinator on pin wake
// - node options 0 to 15, reset zero
// - hub bit0 reselects network number by scan
// - hub bit1 reselects channel by energy scan
// - hub bit2 accepts or refuses joining nodes
// - hub options 0 to 7, reset zero
// - standard mask 0xFFFF, high power 0x3FFE
module nsc_top #(
  parameter HIGH_POWER     = 0,
  parameter LOOKUP_CYCLES  = `NSC_LOOKUP_CYC,
  parameter BASE_CYCLES    = `NSC_BASE_CYC
) (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  // command port
  input  wire        i_cmd_enter,
  input  wire        i_cmd_valid,
  input  wire        i_cmd_write,
  input  wire [2:0]  i_cmd_code,
  input  wire [31:0] i_cmd_data,
  output reg         o_rsp_valid,
  output reg         o_rsp_ok,
  output reg  [31:0] o_rsp_data,
  output reg         o_cmd_mode,
  // name lookup
  input  wire        i_lookup_valid,
  input  wire [4:0]  i_lookup_len,
  output reg         o_lookup_req,
  input  wire        i_node_found,
  input  wire [31:0] i_node_addr_hi,
  input  wire [31:0] i_node_addr_lo,
  output reg  [31:0] o_dest_addr_hi,
  output reg  [31:0] o_dest_addr_lo,
  // scans
  input  wire        i_scan_start,
  input  wire        i_scan_energy,
  output wire        o_scan_busy,
  output wire [7:0]  o_scan_chan,
  output wire        o_scan_done,
  output reg         o_scan_energy,
  // join settings to the radio
  input  wire        i_beacon_mode,
  input  wire        i_pin_wake,
  output reg         o_role_coord,
  output reg  [15:0] o_channel_mask,
  output reg  [3:0]  o_dwell_exponent,
  output reg         o_join_any_pan,
  output reg         o_join_any_chan,
  output reg         o_auto_join,
  output reg         o_pan_reselect,
  output reg         o_freq_reselect,
  output reg         o_accept_joiners,
  output reg         o_poll_req
);

  ////////////////////////////////////////////////////////////////////////
  // state and storage

  localparam [2:0] LK_IDLE = 3'b001;  // no lookup running
  localparam [2:0] LK_WAIT = 3'b010;  // waiting for a node answer
  localparam [2:0] LK_DONE = 3'b100;  // answer sent, leaving mode

  reg [2:0]  lk_state_reg;            // lookup state
  reg [2:0]  lk_state_next;
  reg [31:0] lk_cnt_reg;              // lookup timeout counter
  reg [31:0] lk_cnt_next;
  reg [7:0]  node_opt_reg;            // end-node join options
  reg [7:0]  hub_opt_reg;             // coordinator join options
  reg        wake_s1_reg;             // pin wake sync, first stage
  reg        wake_s2_reg;             // pin wake sync, second stage
  reg        wake_d_reg;              // delayed copy for edge find
  reg        ok_next;                 // command answer, ok flag
  reg [31:0] data_next;               // command answer, read data
  reg        wr_next;                 // command is a legal write

  // mask allowed by the fitted variant
  wire [15:0] mask_allowed;
  assign mask_allowed = (HIGH_POWER != 0) ? `NSC_MASK_HP : 16'hFFFF;

  // true when a value fits under a limit
  function in_range;
    input [31:0] value;
    input [31:0] limit;
    begin
      in_range = (value <= limit);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // command decode: read or checked write of one setting

  always @* begin
    ok_next   = o_cmd_mode;
    data_next = 32'h00000000;
    wr_next   = 1'b0;
    case (i_cmd_code)
      `NSC_CMD_ROLE: begin
        data_next = {31'h0, o_role_coord};
        if (i_cmd_write) begin
          ok_next = ok_next && in_range(i_cmd_data, `NSC_ROLE_MAX);
        end
      end
      `NSC_CMD_MASK: begin
        data_next = {16'h0000, o_channel_mask};
        if (i_cmd_write) begin
          // forbidden channel bits are an error
          ok_next = ok_next && in_range(i_cmd_data, `NSC_MASK_MAX) &&
                    ((i_cmd_data[15:0] & ~mask_allowed) == 16'h0000);
        end
      end
      `NSC_CMD_DWELL: begin
        data_next = {28'h0, o_dwell_exponent};
        if (i_cmd_write) begin
          ok_next = ok_next && in_range(i_cmd_data, `NSC_DWELL_MAX);
        end
      end
      `NSC_CMD_NODE_OPT: begin
        data_next = {24'h0, node_opt_reg};
        if (i_cmd_write) begin
          // reserved upper bits may not be set
          ok_next = ok_next && in_range(i_cmd_data, `NSC_NODE_OPT_MAX);
        end
      end
      `NSC_CMD_HUB_OPT: begin
        data_next = {24'h0, hub_opt_reg};
        if (i_cmd_write) begin
          // reserved upper bits may not be set
          ok_next = ok_next && in_range(i_cmd_data, `NSC_HUB_OPT_MAX);
        end
      end
      `NSC_CMD_DEST_LO: begin
        data_next = o_dest_addr_lo;
        ok_next   = ok_next && !i_cmd_write;
      end
      `NSC_CMD_DEST_HI: begin
        data_next = o_dest_addr_hi;
        ok_next   = ok_next && !i_cmd_write;
      end
      default: begin
        // unknown command
        ok_next = 1'b0;
      end
    endcase
    wr_next = i_cmd_write && ok_next;
    if (!ok_next) begin
      data_next = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lookup state machine

  always @* begin
    lk_state_next = lk_state_reg;
    lk_cnt_next   = lk_cnt_reg;
    case (lk_state_reg)
      LK_IDLE: begin
        lk_cnt_next = 32'h00000000;
        // blank or overlong names end at once with error
        if (i_lookup_valid && o_cmd_mode && (i_lookup_len != 5'h00) &&
            (i_lookup_len <= `NSC_NAME_MAX)) begin
          lk_state_next = LK_WAIT;
        end
      end
      LK_WAIT: begin
        lk_cnt_next = lk_cnt_reg + 32'h00000001;
        if (i_node_found) begin
          lk_state_next = LK_DONE;
        end else if (lk_cnt_reg >= LOOKUP_CYCLES - 1) begin
          lk_state_next = LK_IDLE;
        end
      end
      LK_DONE: begin
        lk_state_next = LK_IDLE;
      end
      default: begin
        lk_state_next = LK_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // lookup, answers and command mode

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      lk_state_reg   <= LK_IDLE;
      lk_cnt_reg     <= 32'h00000000;
      o_rsp_valid    <= 1'b0;
      o_rsp_ok       <= 1'b0;
      o_rsp_data     <= 32'h00000000;
      o_cmd_mode     <= 1'b0;
      o_lookup_req   <= 1'b0;
      o_dest_addr_hi <= 32'h00000000;
      o_dest_addr_lo <= 32'h00000000;
    end else begin
      lk_state_reg <= lk_state_next;
      lk_cnt_reg   <= lk_cnt_next;
      o_rsp_valid  <= 1'b0;
      o_lookup_req <= 1'b0;
      if (i_cmd_enter) begin
        o_cmd_mode <= 1'b1;
      end
      if (lk_state_reg == LK_IDLE && i_lookup_valid) begin
        if (lk_state_next == LK_WAIT) begin
          o_lookup_req <= 1'b1;             // ask the radio for the node
        end else begin
          o_rsp_valid <= 1'b1;              // blank name: error
          o_rsp_ok    <= 1'b0;
          o_rsp_data  <= 32'h00000000;
        end
      end else if (lk_state_reg == LK_WAIT) begin
        if (i_node_found) begin
          o_dest_addr_hi <= i_node_addr_hi;
          o_dest_addr_lo <= i_node_addr_lo;
          o_rsp_valid    <= 1'b1;           // ok answer
          o_rsp_ok       <= 1'b1;
          o_rsp_data     <= 32'h00000000;
        end else if (lk_state_next == LK_IDLE) begin
          o_rsp_valid <= 1'b1;              // timeout: error
          o_rsp_ok    <= 1'b0;
          o_rsp_data  <= 32'h00000000;
        end
      end else if (lk_state_reg == LK_DONE) begin
        o_cmd_mode <= 1'b0;                 // leave mode unasked
      end else if (i_cmd_valid) begin
        o_rsp_valid <= 1'b1;
        o_rsp_ok    <= ok_next;
        o_rsp_data  <= data_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settings written by commands

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_role_coord     <= `NSC_ROLE_RST;
      o_channel_mask   <= `NSC_MASK_RST;
      o_dwell_exponent <= `NSC_DWELL_RST;
      node_opt_reg     <= `NSC_NODE_OPT_RST;
      hub_opt_reg      <= `NSC_HUB_OPT_RST;
    end else if (i_cmd_valid && wr_next && lk_state_reg == LK_IDLE &&
                 !i_lookup_valid) begin
      case (i_cmd_code)
        `NSC_CMD_ROLE: begin
          o_role_coord <= i_cmd_data[0];
        end
        `NSC_CMD_MASK: begin
          o_channel_mask <= i_cmd_data[15:0] & mask_allowed;
        end
        `NSC_CMD_DWELL: begin
          o_dwell_exponent <= i_cmd_data[3:0];
        end
        `NSC_CMD_NODE_OPT: begin
          node_opt_reg <= {4'h0, i_cmd_data[3:0]};
        end
        `NSC_CMD_HUB_OPT: begin
          hub_opt_reg <= {5'h00, i_cmd_data[2:0]};
        end
        default: begin
          // destination words are loaded by lookup only
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // join behaviour decoded from the role and options

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_join_any_pan   <= 1'b0;
      o_join_any_chan  <= 1'b0;
      o_auto_join      <= 1'b0;
      o_pan_reselect   <= 1'b0;
      o_freq_reselect  <= 1'b0;
      o_accept_joiners <= 1'b0;
      o_scan_energy    <= 1'b0;
    end else begin
      // end-node options only count as end node
      o_join_any_pan  <= !o_role_coord &&
                         node_opt_reg[`NSC_NODE_ANY_PAN];
      o_join_any_chan <= !o_role_coord &&
                         node_opt_reg[`NSC_NODE_ANY_CH];
      // beacon networks join regardless of the bit
      o_auto_join     <= !o_role_coord &&
                         (node_opt_reg[`NSC_NODE_AUTO] ||
                          i_beacon_mode);
      // coordinator options only count as coordinator
      o_pan_reselect   <= o_role_coord &&
                          hub_opt_reg[`NSC_HUB_PAN_RES];
      o_freq_reselect  <= o_role_coord &&
                          hub_opt_reg[`NSC_HUB_FREQ_RES];
      o_accept_joiners <= o_role_coord &&
                          hub_opt_reg[`NSC_HUB_ACCEPT];
      if (i_scan_start && !o_scan_busy) begin
        o_scan_energy <= i_scan_energy;     // kind of the scan running
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin wake: synchronise, then poll on the rising edge

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_d_reg  <= 1'b0;
      o_poll_req  <= 1'b0;
    end else begin
      wake_s1_reg <= i_pin_wake;
      wake_s2_reg <= wake_s1_reg;
      wake_d_reg  <= wake_s2_reg;
      o_poll_req  <= wake_s2_reg && !wake_d_reg && !o_role_coord &&
                     node_opt_reg[`NSC_NODE_POLL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan engine; all scans share the mask and dwell

  nsc_scan_walk #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_walk (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (i_scan_start),
    .i_mask    (o_channel_mask),
    .i_dwell   (o_dwell_exponent),
    .o_busy    (o_scan_busy),
    .o_chan    (o_scan_chan),
    .o_done    (o_scan_done)
  );

endmodule
`default_nettype wire

// ===== nsc_top_monitor.sv
// assertions for the join and scan block
`timescale 1ns/10ps
`default_nettype none
`include "nsc_regs.vh"
module nsc_top_monitor #(
  parameter HIGH_POWER    = 0,
  parameter LOOKUP_CYCLES = 50
) (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  // command port
  input wire logic        i_cmd_valid,
  input wire logic        i_cmd_write,
  input wire logic [2:0]  i_cmd_code,
  input wire logic [31:0] i_cmd_data,
  input wire logic        o_rsp_valid,
  input wire logic        o_rsp_ok,
  input wire logic        o_cmd_mode,
  // name lookup
  input wire logic        i_lookup_valid,
  input wire logic [4:0]  i_lookup_len,
  input wire logic        o_lookup_req,
  input wire logic        i_node_found,
  input wire logic [31:0] i_node_addr_lo,
  input wire logic [31:0] o_dest_addr_lo,
  // scans and settings
  input wire logic        i_scan_start,
  input wire logic        o_scan_busy,
  input wire logic [7:0]  o_scan_chan,
  input wire logic [15:0] o_channel_mask,
  input wire logic [3:0]  o_dwell_exponent,
  input wire logic        o_role_coord,
  input wire logic        o_join_any_pan,
  input wire logic        o_pan_reselect,
  input wire logic        o_accept_joiners,
  input wire logic        o_poll_req
);
  logic        look_busy; // lookup in flight
  logic        look_wait; // waiting on the radio
  logic [15:0] scan_mask; // mask latched at scan start
  int unsigned wait_cnt;  // cycles spent waiting
  wire         cmd_go  = i_cmd_valid && i_cmd_write && o_cmd_mode &&
                         !look_busy && !i_lookup_valid;
  wire  [7:0]  chan_off = o_scan_chan - `NSC_CHAN_BASE;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////
  // lookup and scan state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      look_busy <= 1'b0;
      look_wait <= 1'b0;
      wait_cnt  <= 0;
      scan_mask <= 16'h0000;
    end else begin
      if (i_lookup_valid && !look_busy) look_busy <= 1'b1;
      else if (o_rsp_valid) look_busy <= 1'b0;
      if (o_lookup_req) look_wait <= 1'b1;
      else if (o_rsp_valid) look_wait <= 1'b0;
      wait_cnt <= look_wait ? wait_cnt + 1 : 0;
      if (i_scan_start && !o_scan_busy) scan_mask <= o_channel_mask;
    end
  end
  ////////////////////////////////////////////////////////////////////
  a_reset_values: assert property ($rose(i_rst_n) |-> o_channel_mask ==
    `NSC_MASK_RST && o_dwell_exponent == `NSC_DWELL_RST && !o_role_coord)
    else $error("bad reset");
  a_dwell_write: assert property (cmd_go && i_cmd_code == `NSC_CMD_DWELL
    && i_cmd_data <= `NSC_DWELL_MAX |=> o_rsp_valid && o_rsp_ok &&
    o_dwell_exponent == $past(i_cmd_data[3:0]))
    else $error("dwell write");
  a_node_range: assert property (cmd_go && i_cmd_code == `NSC_CMD_NODE_OPT
    && i_cmd_data > `NSC_NODE_OPT_MAX |=> o_rsp_valid && !o_rsp_ok)
    else $error("node range");
  a_hub_range: assert property (cmd_go && i_cmd_code == `NSC_CMD_HUB_OPT
    && i_cmd_data > `NSC_HUB_OPT_MAX |=> o_rsp_valid && !o_rsp_ok)
    else $error("hub range");
  a_dest_refuse: assert property (cmd_go && i_cmd_code == `NSC_CMD_DEST_LO
    |=> o_rsp_valid && !o_rsp_ok && $stable(o_dest_addr_lo))
    else $error("dest write");
  a_lookup_load: assert property (look_wait && i_node_found |=> o_rsp_valid
    && o_rsp_ok && o_dest_addr_lo == $past(i_node_addr_lo) ##1 !o_cmd_mode)
    else $error("lookup load");
  a_lookup_blank: assert property (i_lookup_valid && !look_busy &&
    i_lookup_len == 5'h00 |=> o_rsp_valid && !o_rsp_ok)
    else $error("blank lookup");
  a_lookup_bound: assert property (look_wait |-> wait_cnt <=
    LOOKUP_CYCLES + 2) else $error("lookup wait");
  a_mask_legal: assert property ((o_channel_mask & ~(HIGH_POWER ?
    `NSC_MASK_HP : 16'hFFFF)) == 16'h0000)
    else $error("mask bits");
  a_scan_chan: assert property (o_scan_busy |-> o_scan_chan >= 8'h0B &&
    o_scan_chan <= 8'h1A && scan_mask[chan_off[3:0]])
    else $error("scan channel");
  a_hub_gate: assert property ((!o_role_coord) [*2] |-> !o_pan_reselect
    && !o_accept_joiners) else $error("hub gate");
  a_node_gate: assert property (o_role_coord [*2] |-> !o_join_any_pan &&
    !o_poll_req) else $error("node gate");
endmodule
bind nsc_top nsc_top_monitor #(.HIGH_POWER(HIGH_POWER),
  .LOOKUP_CYCLES(LOOKUP_CYCLES)) u_mon (.*);
`default_nettype wire

// ===== nsc_top_tb.sv
// self-checking bench for the join and scan configuration block
`timescale 1ns/10ps
`default_nettype none
`include "nsc_regs.vh"
module nsc_top_tb;
  localparam LK = 50; // shortened lookup wait
  localparam BC = 4;  // shortened base period
  logic        i_ref_clk, i_rst_n, i_cmd_enter, i_cmd_valid, i_cmd_write;
  logic        i_lookup_valid, i_node_found, i_scan_start, i_scan_energy;
  logic        i_beacon_mode, i_pin_wake, ans_en;
  logic [2:0]  i_cmd_code;
  logic [4:0]  i_lookup_len;
  logic [31:0] i_cmd_data, i_node_addr_hi, i_node_addr_lo;
  logic        o_rsp_valid, o_rsp_ok, o_cmd_mode, o_lookup_req;
  logic        o_scan_busy, o_scan_done, o_scan_energy, o_role_coord;
  logic        o_join_any_pan, o_join_any_chan, o_auto_join, o_poll_req;
  logic        o_pan_reselect, o_freq_reselect, o_accept_joiners;
  logic [3:0]  o_dwell_exponent;
  logic [7:0]  o_scan_chan;
  logic [15:0] o_channel_mask;
  logic [31:0] o_rsp_data, o_dest_addr_hi, o_dest_addr_lo;
  int          bad_count, n_checks, cnt;
  nsc_top #(.HIGH_POWER(0), .LOOKUP_CYCLES(LK), .BASE_CYCLES(BC))
    u_dut (.*);
  nsc_radio_model u_radio (.i_clk(i_ref_clk), .i_answer_en(ans_en),
    .i_delay(8'h02), .i_addr_hi(32'h0013A2C5), .i_addr_lo(32'h4052B1C7),
    .i_lookup_req(o_lookup_req), .o_found(i_node_found),
    .o_addr_hi(i_node_addr_hi), .o_addr_lo(i_node_addr_lo));
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////////////////////////////////
  // compare helpers and verdict
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // one command, answer seen on return
  task automatic cmd(input logic wr, input logic [2:0] c, input int d);
    @(negedge i_ref_clk);
    i_cmd_valid = 1'b1;
    i_cmd_write = wr;
    i_cmd_code = c;
    i_cmd_data = d;
    @(negedge i_ref_clk);
    i_cmd_valid = 1'b0;
  endtask
  task automatic enter;
    @(negedge i_ref_clk);
    i_cmd_enter = 1'b1;
    @(negedge i_ref_clk);
    i_cmd_enter = 1'b0;
  endtask
  // start a lookup, count cycles to answer
  task automatic lookup(input logic [4:0] len);
    @(negedge i_ref_clk);
    i_lookup_valid = 1'b1;
    i_lookup_len = len;
    @(negedge i_ref_clk);
    i_lookup_valid = 1'b0;
    cnt = 0;
    while (o_rsp_valid !== 1'b1 && cnt < LK + 20) begin
      @(negedge i_ref_clk);
      cnt++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // reset values, refusal, readback
  task t_reset;
    logic [31:0] rv [5] = '{0, 32'h1FFE, 4, 0, 0};
    chk_val(o_channel_mask, `NSC_MASK_RST);
    chk_val(o_dwell_exponent, `NSC_DWELL_RST);
    chk_bit(o_role_coord, 1'b0);
    cmd(1'b0, `NSC_CMD_ROLE, 0);
    chk_bit(o_rsp_ok, 1'b0);
    enter();
    for (int i = 0; i < 5; i++) begin
      cmd(1'b0, i[2:0], 0);
      chk_val(o_rsp_data, rv[i]);
    end
  endtask
  // range tops accepted, one above refused
  task t_ranges;
    int good [5] = '{1, 32'hFFFF, 15, 15, 7};
    for (int i = 0; i < 5; i++) begin
      cmd(1'b1, i[2:0], good[i]);
      chk_bit(o_rsp_ok, 1'b1);
      cmd(1'b1, i[2:0], good[i] + 1);
      chk_bit(o_rsp_ok, 1'b0);
      cmd(1'b0, i[2:0], 0);
      chk_val(o_rsp_data, good[i]);
    end
    cmd(1'b1, `NSC_CMD_DEST_LO, 1);
    chk_bit(o_rsp_ok, 1'b0);
  endtask
  // option bits gated by role
  task t_options;
    cmd(1'b1, `NSC_CMD_ROLE, 0);
    cmd(1'b1, `NSC_CMD_NODE_OPT, 15);
    @(negedge i_ref_clk);
    chk_val({o_join_any_pan, o_join_any_chan, o_auto_join}, 3'h7);
    chk_bit(o_accept_joiners, 1'b0);
    i_pin_wake = 1'b1;
    cnt = 0;
    repeat (8) @(negedge i_ref_clk) cnt += o_poll_req;
    chk_val(cnt, 1);
    i_pin_wake = 1'b0;
    cmd(1'b1, `NSC_CMD_NODE_OPT, 0);
    i_beacon_mode = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk_bit(o_auto_join, 1'b1);
    i_beacon_mode = 1'b0;
    cmd(1'b1, `NSC_CMD_ROLE, 1);
    @(negedge i_ref_clk);
    chk_val({o_pan_reselect, o_freq_reselect, o_accept_joiners}, 3'h7);
    cmd(1'b1, `NSC_CMD_HUB_OPT, 0);
    @(negedge i_ref_clk);
    chk_val({o_pan_reselect, o_freq_reselect, o_accept_joiners}, 3'h0);
  endtask
  // edge channels, dwell 1, empty mask
  task t_scan;
    int n0;
    n0 = 0;
    cnt = 0;
    cmd(1'b1, `NSC_CMD_MASK, 32'h8001);
    cmd(1'b1, `NSC_CMD_DWELL, 1);
    @(negedge i_ref_clk);
    i_scan_start = 1'b1;
    i_scan_energy = 1'b1;
    @(negedge i_ref_clk);
    i_scan_start = 1'b0;
    chk_bit(o_scan_energy, 1'b1);
    chk_val(o_scan_chan, 8'h0B);
    while (o_scan_busy === 1'b1 && cnt < 100) begin
      n0 += (o_scan_chan === 8'h0B);
      cnt++;
      @(negedge i_ref_clk);
    end
    chk_val(cnt, 4 * BC);
    chk_val(n0, 2 * BC);
    chk_bit(o_scan_done, 1'b1);
    cmd(1'b1, `NSC_CMD_MASK, 0);
    i_scan_start = 1'b1;
    @(negedge i_ref_clk);
    i_scan_start = 1'b0;
    chk_val({o_scan_busy, o_scan_done}, 2'h1);
  endtask
  // found, blank, too long, and silent lookups
  task t_lookup;
    ans_en = 1'b1;
    lookup(5'h14);
    chk_bit(o_rsp_ok, 1'b1);
    chk_val(o_dest_addr_hi, 32'h0013A2C5);
    chk_val(o_dest_addr_lo, 32'h4052B1C7);
    @(negedge i_ref_clk);
    chk_bit(o_cmd_mode, 1'b0);
    enter();
    lookup(5'h00);
    chk_val({cnt[0], o_rsp_ok}, 2'h0);
    lookup(5'h15);
    chk_bit(o_rsp_ok, 1'b0);
    ans_en = 1'b0;
    lookup(5'h05);
    chk_bit(o_rsp_ok, 1'b0);
    chk_bit(cnt >= LK && cnt <= LK + 3, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_cmd_enter, i_cmd_valid, i_cmd_write, i_lookup_valid} = 4'h0;
    {i_scan_start, i_scan_energy, i_beacon_mode, i_pin_wake} = 4'h0;
    {i_cmd_code, i_lookup_len, i_cmd_data} = 40'h0;
    {ans_en, bad_count, n_checks} = 0;
    i_rst_n = 1'b0;
    repeat (5) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_ranges();
    t_options();
    t_scan();
    t_lookup();
    complete_run();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
